/* rtl/pfo_port_f_override.sv */
// override logic between the port F / port G top-pin registers and their pad drivers
//
// Function
// - test port on forces TDI/TMS/TCK pull-ups, even in reset
// - test port on takes four pins from port
// - TDI held pulled-up input, level to scan logic
// - TDO driven from scan data, pull-up off
// - TDO driver enabled only in shift states
// - scan operations sequenced on tester TCK edges
// - front-end enable makes pin 3 RX/TX output
// - antenna enable makes pin 2 antenna select
// - pins feed converter; pins 0,1 never overridden
// - compare-B reaches top pin only when output
// - top pin carries timer waveform in PWM
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
module pfo_port_f_override (
  input  wire logic                  clk_sys_i,
  input  wire logic                  sys_rst_i,
  // register bus, AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // test-port enable level (fuse or strap, asynchronous)
  input  wire logic                  test_port_enable_i,
  // scan controller, same clock
  input  wire logic                  tap_shift_ir_i,
  input  wire logic                  tap_shift_dr_i,
  input  wire logic                  tap_tdo_i,
  output pfo_pkg::pfo_tap_pins_t     tap_pins_o,
  // radio front-end signals, same clock
  input  wire logic                  rxtx_indicator_out_i,
  input  wire logic                  antenna_select_out_i,
  // timer 0 compare-B, same clock
  input  wire logic                  timer0_compare_b_en_i,
  input  wire logic                  timer0_compare_b_out_i,
  input  wire logic                  timer0_pwm_mode_i,
  input  wire logic                  timer0_pwm_wave_i,
  // port F pads
  input  wire logic [7:0]            pf_pad_i,
  output pfo_pkg::pfo_pad_t          pf_pad_o,
  // port G top pad
  input  wire logic                  pg_top_pad_i,
  output logic                       pg_top_out_o,
  output logic                       pg_top_oe_o
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [7:0]            pf_meta_r;
  logic [7:0]            pf_sync_r;
  logic                  pg_meta_r;
  logic                  pg_sync_r;
  logic                  tpe_meta_r;
  logic                  tpe_sync_r;
  logic                  tck_prev_r;

  // pad inputs and the enable strap pass two flops before any logic;
  // the strap chain is left out of reset so the forced pull-ups hold through it
  always_ff @(posedge clk_sys_i) begin
    pf_meta_r  <= pf_pad_i;
    pf_sync_r  <= pf_meta_r;
    pg_meta_r  <= pg_top_pad_i;
    pg_sync_r  <= pg_meta_r;
    tpe_meta_r <= test_port_enable_i;
    tpe_sync_r <= tpe_meta_r;
  end

  wire logic test_port_enable = tpe_sync_r;

  // ************************************************************
  // software registers
  // ************************************************************
  logic [7:0]            radio_control_one_r;
  logic [7:0]            antenna_diversity_reg_r;
  logic [7:0]            pf_dir_r;
  logic [7:0]            pf_port_r;
  logic [7:0]            pg_ctrl_r;

  wire logic front_end_ctrl_enable = radio_control_one_r[pfo_pkg::PFO_FRONT_END_EN_BIT];
  wire logic antenna_switch_enable = antenna_diversity_reg_r[pfo_pkg::PFO_ANT_SW_EN_BIT];
  wire logic pg_top_direction_bit  = pg_ctrl_r[pfo_pkg::PFO_PG_DIR_BIT];
  wire logic pg_top_port_bit       = pg_ctrl_r[pfo_pkg::PFO_PG_PORT_BIT];
  wire logic pull_up_disable       = pg_ctrl_r[pfo_pkg::PFO_PUD_BIT];

  // ************************************************************
  // override sources
  // ************************************************************
  pfo_pkg::pfo_ovr_t     ovr;
  wire logic [3:0] tpe4      = {4{test_port_enable}};
  wire logic       shift_any = tap_shift_ir_i | tap_shift_dr_i;

  // top four pins belong to the test port while it is enabled
  assign ovr.pullup_override_en        = {tpe4, 4'h0};
  assign ovr.pullup_override_val       = {1'b1, 1'b0, 1'b1, 1'b1, 4'h0};
  assign ovr.direction_override_en     = {tpe4, front_end_ctrl_enable,
                                          antenna_switch_enable, 2'h0};
  // TDO drives only in a shift state, tri-stated otherwise
  assign ovr.direction_override_val    = {1'b0, shift_any, 2'h0, front_end_ctrl_enable,
                                          antenna_switch_enable, 2'h0};
  assign ovr.value_override_en         = {1'b0, test_port_enable, 2'h0,
                                          front_end_ctrl_enable,
                                          antenna_switch_enable, 2'h0};
  assign ovr.value_override_val        = {1'b0, tap_tdo_i, 2'h0, rxtx_indicator_out_i,
                                          antenna_select_out_i, 2'h0};
  // converter pins 0 and 1 never see a pull-up or input override
  assign ovr.input_enable_override_en  = {tpe4, 4'h0};
  assign ovr.input_enable_override_val = 8'h00;

  // ************************************************************
  // port-register (normal) pad settings
  // ************************************************************
  wire logic [7:0] norm_pu = ~pf_dir_r & pf_port_r & {8{~pull_up_disable}};
  wire logic [7:0] norm_oe = pf_dir_r;
  wire logic [7:0] norm_ov = pf_port_r;
  wire logic [7:0] norm_ie = 8'hFF;

  // choose the override value when its enable is set
  function automatic logic pfo_pick(input logic en, input logic val, input logic norm);
    pfo_pick = en ? val : norm;
  endfunction

  pfo_pkg::pfo_pad_t     pad_nxt;

  // the same selection stands in front of each pad control of each pin
  for (genvar n = 0; n < 8; n++) begin : g_pin
    assign pad_nxt.pull_up[n] = pfo_pick(ovr.pullup_override_en[n],
                                         ovr.pullup_override_val[n], norm_pu[n]);
    assign pad_nxt.out_en[n]  = pfo_pick(ovr.direction_override_en[n],
                                         ovr.direction_override_val[n], norm_oe[n]);
    assign pad_nxt.out_val[n] = pfo_pick(ovr.value_override_en[n],
                                         ovr.value_override_val[n], norm_ov[n]);
    assign pad_nxt.in_en[n]   = pfo_pick(ovr.input_enable_override_en[n],
                                         ovr.input_enable_override_val[n], norm_ie[n]);
  end

  // in reset every pad floats as an input, but the test pull-ups stay on
  wire logic [7:0] rst_pu = pfo_pkg::PFO_TEST_PU_MASK & {8{test_port_enable}};

  pfo_pkg::pfo_pad_t     pad_r;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pad_r <= '{pull_up: rst_pu, out_en: 8'h00, out_val: 8'h00, in_en: 8'hFF};
    end else begin
      pad_r <= pad_nxt;
    end
  end

  assign pf_pad_o = pad_r;

  // ************************************************************
  // port G top pin: timer compare-B
  // ************************************************************
  // the compare output only takes the value; direction stays with software,
  // so an input-configured pin never shows the timer
  wire logic pg_val_ovr_en = timer0_compare_b_en_i;
  wire logic pg_timer_val  = timer0_pwm_mode_i ? timer0_pwm_wave_i
                                               : timer0_compare_b_out_i;
  wire logic pg_out_nxt    = pfo_pick(pg_val_ovr_en, pg_timer_val, pg_top_port_bit);
  logic                  pg_out_r;
  logic                  pg_oe_r;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pg_out_r <= 1'b0;
      pg_oe_r  <= 1'b0;
    end else begin
      pg_out_r <= pg_out_nxt;
      pg_oe_r  <= pg_top_direction_bit;
    end
  end

  assign pg_top_out_o = pg_out_r;
  assign pg_top_oe_o  = pg_oe_r;

  // ************************************************************
  // test-port pins towards the scan controller
  // ************************************************************
  // TCK is sampled on the system clock, so it must stay well below its rate
  wire logic tck_lvl = pf_sync_r[pfo_pkg::PFO_PIN_TCK];
  pfo_pkg::pfo_tap_pins_t tap_r;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tck_prev_r <= 1'b1;
      tap_r      <= '{tdi: 1'b1, tms: 1'b1, tck_rise: 1'b0, tck_fall: 1'b0};
    end else begin
      tck_prev_r     <= tck_lvl;
      tap_r.tdi      <= pf_sync_r[pfo_pkg::PFO_PIN_TDI] | ~test_port_enable;
      tap_r.tms      <= pf_sync_r[pfo_pkg::PFO_PIN_TMS] | ~test_port_enable;
      tap_r.tck_rise <= test_port_enable & tck_lvl & ~tck_prev_r;
      tap_r.tck_fall <= test_port_enable & ~tck_lvl & tck_prev_r;
    end
  end

  assign tap_pins_o = tap_r;

  // ************************************************************
  // register bus: write channel
  // ************************************************************
  logic                  aw_held_r;
  logic                  w_held_r;
  logic [7:0]            awaddr_r;
  logic [7:0]            wbyte_r;
  logic                  wstrb0_r;
  logic                  awready_r;
  logic                  wready_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;

  wire logic aw_take  = s_axi_awvalid & awready_r;
  wire logic w_take   = s_axi_wvalid & wready_r;
  wire logic do_write = aw_held_r & w_held_r & ~bvalid_r;
  wire logic b_done   = bvalid_r & s_axi_bready;

  // address decode, shared by reads and writes
  function automatic logic pfo_hit(input logic [7:0] a, input logic [7:0] ofs);
    pfo_hit = (a == ofs);
  endfunction

  wire logic wr_writable = pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_RADIO_CTRL1) |
                           pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_ANTENNA_DIVERSITY_REG) |
                           pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_PF_DIR) |
                           pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_PF_PORT) |
                           pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_PG_CTRL);
  wire logic wr_readonly = pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_PF_PIN) |
                           pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_STATUS);
  wire logic wr_en       = do_write & wstrb0_r & wr_writable;

  wire logic aw_held_nxt = (aw_held_r | aw_take) & ~do_write;
  wire logic w_held_nxt  = (w_held_r | w_take) & ~do_write;
  wire logic bvalid_nxt  = do_write | (bvalid_r & ~b_done);

  // address and data are caught independently, in either order;
  // ready stays low on a channel while its item waits or a response is owed
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= pfo_pkg::PFO_RESP_OKAY;
      awaddr_r  <= 8'h00;
      wbyte_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awready_r <= ~aw_held_nxt & ~bvalid_nxt;
      wready_r  <= ~w_held_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_take) begin
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (w_take) begin
        wbyte_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bresp_r <= (wr_writable | wr_readonly) ? pfo_pkg::PFO_RESP_OKAY
                                               : pfo_pkg::PFO_RESP_SLVERR;
      end
    end
  end

  // register storage; reserved bits are not kept and read as zero
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      radio_control_one_r     <= pfo_pkg::PFO_REG_RST;
      antenna_diversity_reg_r <= pfo_pkg::PFO_REG_RST;
      pf_dir_r                <= pfo_pkg::PFO_REG_RST;
      pf_port_r               <= pfo_pkg::PFO_REG_RST;
      pg_ctrl_r               <= pfo_pkg::PFO_REG_RST;
    end else if (wr_en) begin
      if (pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_RADIO_CTRL1)) begin
        radio_control_one_r <= wbyte_r & 8'h01;
      end
      if (pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_ANTENNA_DIVERSITY_REG)) begin
        antenna_diversity_reg_r <= wbyte_r & 8'h01;
      end
      if (pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_PF_DIR)) begin
        pf_dir_r <= wbyte_r;
      end
      if (pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_PF_PORT)) begin
        pf_port_r <= wbyte_r;
      end
      if (pfo_hit(awaddr_r, pfo_pkg::PFO_OFS_PG_CTRL)) begin
        pg_ctrl_r <= wbyte_r & 8'h07;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // ************************************************************
  // register bus: read channel
  // ************************************************************
  logic                  arready_r;
  logic                  rvalid_r;
  logic [31:0]           rdata_r;
  logic [1:0]            rresp_r;

  wire logic [7:0] ra = {s_axi_araddr[7:2], 2'h0};
  // digital input as the pad sees it: zero where the input is disabled
  wire logic [7:0] pin_view = pf_sync_r & pad_r.in_en;
  wire logic [7:0] status_view;

  assign status_view = {4'h0, pg_sync_r, pg_oe_r, shift_any & test_port_enable,
                        test_port_enable};

  wire logic [7:0] rd_byte =
      pfo_hit(ra, pfo_pkg::PFO_OFS_RADIO_CTRL1) ? radio_control_one_r :
      pfo_hit(ra, pfo_pkg::PFO_OFS_ANTENNA_DIVERSITY_REG)     ? antenna_diversity_reg_r :
      pfo_hit(ra, pfo_pkg::PFO_OFS_PF_DIR)      ? pf_dir_r :
      pfo_hit(ra, pfo_pkg::PFO_OFS_PF_PORT)     ? pf_port_r :
      pfo_hit(ra, pfo_pkg::PFO_OFS_PG_CTRL)     ? pg_ctrl_r :
      pfo_hit(ra, pfo_pkg::PFO_OFS_PF_PIN)      ? pin_view :
      pfo_hit(ra, pfo_pkg::PFO_OFS_STATUS)      ? status_view : 8'h00;
  wire logic rd_mapped = (ra <= pfo_pkg::PFO_OFS_STATUS);

  wire logic ar_take = s_axi_arvalid & arready_r;
  wire logic r_done  = rvalid_r & s_axi_rready;

  // one read at a time: arready drops while the answer waits
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= pfo_pkg::PFO_RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h00_0000, rd_byte};
      rresp_r   <= rd_mapped ? pfo_pkg::PFO_RESP_OKAY : pfo_pkg::PFO_RESP_SLVERR;
    end else begin
      arready_r <= ~rvalid_r | r_done;
      rvalid_r  <= rvalid_r & ~r_done;
    end
  end

  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

endmodule

/* rtl/pfo_pkg.sv */
// shared constants and carrier types for the port F alternate-function override block
package pfo_pkg;

  // ************************************************************
  // register map (byte addresses on the register bus)
  // ************************************************************
  localparam int unsigned PFO_ADDR_W            = 8;
  localparam logic [7:0]  PFO_OFS_RADIO_CTRL1   = 8'h00;  // radio_control_one
  localparam logic [7:0]  PFO_OFS_ANTENNA_DIVERSITY_REG       = 8'h04;  // antenna_diversity_reg
  localparam logic [7:0]  PFO_OFS_PF_DIR        = 8'h08;  // port F direction
  localparam logic [7:0]  PFO_OFS_PF_PORT       = 8'h0C;  // port F output value / pull-up
  localparam logic [7:0]  PFO_OFS_PG_CTRL       = 8'h10;  // port G top pin and pull-up disable
  localparam logic [7:0]  PFO_OFS_PF_PIN        = 8'h14;  // port F digital input, read only
  localparam logic [7:0]  PFO_OFS_STATUS        = 8'h18;  // block state, read only

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int unsigned PFO_FRONT_END_EN_BIT  = 0;  // in radio_control_one
  localparam int unsigned PFO_ANT_SW_EN_BIT     = 0;  // in antenna_diversity_reg
  localparam int unsigned PFO_PG_DIR_BIT        = 0;  // pg_top_direction_bit
  localparam int unsigned PFO_PG_PORT_BIT       = 1;  // port value of the top pin
  localparam int unsigned PFO_PUD_BIT           = 2;  // global pull-up disable
  localparam int unsigned PFO_ST_TEST_EN_BIT    = 0;
  localparam int unsigned PFO_ST_SHIFT_BIT      = 1;
  localparam int unsigned PFO_ST_PG_OE_BIT      = 2;
  localparam int unsigned PFO_ST_PG_PIN_BIT     = 3;
  localparam logic [7:0]  PFO_REG_RST           = 8'h00;

  // ************************************************************
  // pin positions on port F
  // ************************************************************
  localparam int unsigned PFO_PIN_TDI           = 7;
  localparam int unsigned PFO_PIN_TDO           = 6;
  localparam int unsigned PFO_PIN_TMS           = 5;
  localparam int unsigned PFO_PIN_TCK           = 4;
  localparam int unsigned PFO_PIN_RXTX          = 3;
  localparam int unsigned PFO_PIN_ANT           = 2;
  // pins whose pull-up is forced on while the test port is enabled
  localparam logic [7:0]  PFO_TEST_PU_MASK      = 8'hB0;

  // ************************************************************
  // bus answers
  // ************************************************************
  localparam logic [1:0]  PFO_RESP_OKAY         = 2'h0;
  localparam logic [1:0]  PFO_RESP_SLVERR       = 2'h2;

  // per-pin override enables and values for the four pad controls
  typedef struct packed {
    logic [7:0] pullup_override_en;
    logic [7:0] pullup_override_val;
    logic [7:0] direction_override_en;
    logic [7:0] direction_override_val;
    logic [7:0] value_override_en;
    logic [7:0] value_override_val;
    logic [7:0] input_enable_override_en;
    logic [7:0] input_enable_override_val;
  } pfo_ovr_t;

  // controls for the eight port F pad drivers
  typedef struct packed {
    logic [7:0] pull_up;
    logic [7:0] out_en;
    logic [7:0] out_val;
    logic [7:0] in_en;
  } pfo_pad_t;

  // test-port pin levels and TCK edge pulses handed to the scan controller
  typedef struct packed {
    logic tdi;
    logic tms;
    logic tck_rise;
    logic tck_fall;
  } pfo_tap_pins_t;

endpackage

/* testbench/pfo_pad_model.sv */
// pad-side model: tester on the test pins, pulls and floating lines elsewhere
module pfo_pad_model (
  input  wire logic        clk_sys_i,
  input  pfo_pkg::pfo_pad_t pad_i,
  input  wire logic        pg_out_i,
  input  wire logic        pg_oe_i,
  input  wire logic        tester_on_i,
  input  wire logic        tdi_i,
  input  wire logic        tms_i,
  output logic [7:0]       pf_pad_o,
  output logic             pg_pad_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       tck = 1'h0;
  logic       flip = 1'h0;
  logic [7:0] ext_en;
  // **********
  // pin levels
  // **********
  // tck at 125 ns, parked low between frames, phase unrelated to the system clock
  initial #37 forever #62.5 tck = tester_on_i ? ~tck : 1'h0;
  // released lines keep no level: they change every cycle
  always @(posedge clk_sys_i) flip <= ~flip;
  // the tester drives tdi, tms and tck, never tdo
  assign ext_en = tester_on_i ? 8'hB0 : 8'h00;
  // driven pins pass straight through; no conversion is modelled, so none is upset
  assign pf_pad_o = (pad_i.out_en & pad_i.out_val)
    | (~pad_i.out_en & ext_en & {tdi_i, 1'h0, tms_i, tck, 4'h0})
    | (~pad_i.out_en & ~ext_en & (pad_i.pull_up | {4{flip, ~flip}}));
  assign pg_pad_o = pg_oe_i ? pg_out_i : flip;
endmodule

/* testbench/pfo_override_assertions.sv */
// assertion checker for the port F override block, bound to its top module
module pfo_override_checker (
  input wire logic              clk_sys_i,
  input wire logic              sys_rst_i,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              tap_shift_ir_i,
  input wire logic              tap_shift_dr_i,
  input wire logic              tap_tdo_i,
  input pfo_pkg::pfo_tap_pins_t tap_pins_o,
  input wire logic              timer0_compare_b_en_i,
  input wire logic              timer0_compare_b_out_i,
  input wire logic              timer0_pwm_mode_i,
  input wire logic              timer0_pwm_wave_i,
  input pfo_pkg::pfo_pad_t      pf_pad_o,
  input wire logic              pg_top_out_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // **********
  // checks
  // **********
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // normal input enable is always on, so a cleared pin-4 enable marks the test port
  wire tp_on = !pf_pad_o.in_en[4];
  chk_test_pullups: assert property (tp_on |-> pf_pad_o.pull_up[7:4] == 4'hB)
    else $error("test pull-ups wrong");
  chk_test_claim: assert property (tp_on |-> pf_pad_o.in_en[7:4] == 4'h0
    && pf_pad_o.out_en[5:4] == 2'h0 && !pf_pad_o.out_en[7]) else $error("test pins not claimed");
  chk_tdo_drive: assert property (tp_on && !$past(sys_rst_i) |->
    pf_pad_o.out_en[6] == ($past(tap_shift_ir_i) | $past(tap_shift_dr_i))
    && pf_pad_o.out_val[6] == $past(tap_tdo_i)) else $error("tdo drive wrong");
  chk_low_pins: assert property (pf_pad_o.in_en[1:0] == 2'h3) else $error("pin 0/1 overridden");
  chk_tck_pulse: assert property (tap_pins_o.tck_rise |-> tp_on ##1 !tap_pins_o.tck_rise)
    else $error("tck pulse wrong");
  chk_pg_value: assert property (!$past(sys_rst_i) && $past(timer0_compare_b_en_i) |->
    pg_top_out_o == ($past(timer0_pwm_mode_i) ? $past(timer0_pwm_wave_i)
    : $past(timer0_compare_b_out_i))) else $error("compare output wrong");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule
bind pfo_port_f_override pfo_override_checker u_chk (.clk_sys_i, .sys_rst_i, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .tap_shift_ir_i,
  .tap_shift_dr_i, .tap_tdo_i, .tap_pins_o, .timer0_compare_b_en_i, .timer0_compare_b_out_i,
  .timer0_pwm_mode_i, .timer0_pwm_wave_i, .pf_pad_o, .pg_top_out_o);

/* testbench/pfo_port_f_override_tb_top.sv */
// self-checking bench for the port F override block
module pfo_port_f_override_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i = 1'h0;
  logic        sys_rst_i = 1'h1;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, ten = 1'h1;
  logic        sir = 1'h0, sdr = 1'h0, tdo = 1'h0, rxtx = 1'h0, ant = 1'h0, cben = 1'h0;
  logic        cbo = 1'h0, pwm = 1'h0, wave = 1'h0, run = 1'h0, tdi = 1'h1, tms = 1'h1;
  logic        awr, wrdy, bv, arr, rv, pg_in, pg_out, pg_oe;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  logic [7:0]  pf_in;
  pfo_pkg::pfo_pad_t      pad;
  pfo_pkg::pfo_tap_pins_t tap;
  int          n_mismatch = 0, checks_done = 0, cyc = 0, seen = 0, fell = 0;
  // **********
  // clock, timeout, design and pads
  // **********
  always #2 clk_sys_i = ~clk_sys_i;
  // the run needs about 300 cycles; a hang ends far beyond that
  always @(posedge clk_sys_i) if (++cyc == 20000) begin
    n_mismatch++;
    stop_test();
  end
  pfo_port_f_override u_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .test_port_enable_i(ten),
    .tap_shift_ir_i(sir), .tap_shift_dr_i(sdr), .tap_tdo_i(tdo), .tap_pins_o(tap),
    .rxtx_indicator_out_i(rxtx), .antenna_select_out_i(ant), .timer0_compare_b_en_i(cben),
    .timer0_compare_b_out_i(cbo), .timer0_pwm_mode_i(pwm), .timer0_pwm_wave_i(wave),
    .pf_pad_i(pf_in), .pf_pad_o(pad), .pg_top_pad_i(pg_in), .pg_top_out_o(pg_out),
    .pg_top_oe_o(pg_oe));
  pfo_pad_model u_pads (.clk_sys_i(clk_sys_i), .pad_i(pad), .pg_out_i(pg_out), .pg_oe_i(pg_oe),
    .tester_on_i(run), .tdi_i(tdi), .tms_i(tms), .pf_pad_o(pf_in), .pg_pad_o(pg_in));
  // compare and count
  task chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pads and top pin after n settled cycles: {oe, out, pull_up, out_en, out_val, in_en}
  task pchk(input int n, input logic [39:0] exp);
    repeat (n) @(negedge clk_sys_i);
    chk({6'h0, pg_oe, pg_out, pad}, exp);
  endtask
  // one register access; answers are waited for, never assumed after a fixed count
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys_i);
    {awa, ara, wd, awv, wv, arv} <= {a, a, d, w, w, !w};
    do begin
      @(posedge clk_sys_i);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
      if (arr) arv <= 1'h0;
    end while (!(bv || rv));
    {bry, rry} <= {w, !w};
    @(posedge clk_sys_i);
    chk(40'(w ? br : rr), 40'(er));
    if (!w) chk(40'(rdat), 40'(d));
    {bry, rry} <= 2'h0;
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // test port, radio outputs, then the compare-B pin
  initial begin
    pchk(16, 40'h00_B000_00FF);
    @(posedge clk_sys_i) sys_rst_i <= 1'h0;
    bus(1'h1, pfo_pkg::PFO_OFS_PF_DIR, 32'hFF, 2'h0);
    bus(1'h1, pfo_pkg::PFO_OFS_PF_PORT, 32'h00, 2'h0);
    pchk(2, 40'h00_B00F_000F);
    @(posedge clk_sys_i) {sdr, tdo} <= 2'h3;
    pchk(2, 40'h00_B04F_400F);
    @(posedge clk_sys_i) {sir, sdr, tdo, run, tdi, tms} <= 6'h24;
    pchk(2, 40'h00_B04F_000F);
    // 800 ns of a 125 ns tck: six or seven of each edge, plus the pull-up to low step
    repeat (200) begin
      @(negedge clk_sys_i);
      if (tap.tck_rise === 1'h1) seen++;
      if (tap.tck_fall === 1'h1) fell++;
    end
    chk(40'(seen inside {[6:7]} && fell inside {[6:8]}), 40'h1);
    chk(40'({tap.tdi, tap.tms}), 40'h0);
    bus(1'h0, pfo_pkg::PFO_OFS_PF_PIN, 32'h0, 2'h0);
    $display("test port done");
    @(posedge clk_sys_i) {run, ten} <= 2'h0;
    pchk(8, 40'h00_00FF_00FF);
    bus(1'h1, pfo_pkg::PFO_OFS_RADIO_CTRL1, 32'h1, 2'h0);
    bus(1'h1, pfo_pkg::PFO_OFS_ANTENNA_DIVERSITY_REG, 32'h1, 2'h0);
    bus(1'h1, pfo_pkg::PFO_OFS_PF_DIR, 32'h0, 2'h0);
    bus(1'h1, pfo_pkg::PFO_OFS_PF_PORT, 32'hFFFF_FF03, 2'h0);
    rxtx <= 1'h1;
    pchk(2, 40'h00_030C_0BFF);
    @(posedge clk_sys_i) {rxtx, ant} <= 2'h1;
    pchk(2, 40'h00_030C_07FF);
    bus(1'h0, pfo_pkg::PFO_OFS_RADIO_CTRL1, 32'h1, 2'h0);
    bus(1'h0, 8'h40, 32'h0, 2'h2);
    bus(1'h1, 8'h40, 32'h1, 2'h2);
    bus(1'h1, pfo_pkg::PFO_OFS_RADIO_CTRL1, 32'h0, 2'h0);
    pchk(2, 40'h00_0304_07FF);
    $display("radio outputs done");
    @(posedge clk_sys_i) {cben, cbo} <= 2'h3;
    pchk(2, 40'h01_0304_07FF);
    bus(1'h1, pfo_pkg::PFO_OFS_PG_CTRL, 32'h1, 2'h0);
    pchk(2, 40'h03_0304_07FF);
    @(posedge clk_sys_i) pwm <= 1'h1;
    pchk(2, 40'h02_0304_07FF);
    // global pull-up disable clears the port pull-ups on pins 0 and 1
    bus(1'h1, pfo_pkg::PFO_OFS_PG_CTRL, 32'h5, 2'h0);
    pchk(2, 40'h02_0004_07FF);
    bus(1'h0, pfo_pkg::PFO_OFS_STATUS, 32'h4, 2'h0);
    $display("compare pin done");
    stop_test();
  end
endmodule
